// file: clh_pkg.sv
// Package with the constants and types shared by the cache block.
package clh_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int IDX_W = 4;
    localparam int OFF_W = 2;
    localparam int LINE_WORDS = 4;
    localparam int SETS = 16;
    localparam int TAG_W = ADDR_W - IDX_W - OFF_W - 2;
    localparam int ATTR_W = 4;
    localparam logic [ATTR_W-1:0] ATTR_RESET = 4'h0;
    localparam logic [ATTR_W-1:0] ATTR_CACHEABLE_BIT = 4'h1;
    localparam logic [1:0] CACHE_LEVEL = 2'h1;
    localparam logic [ADDR_W-1:0] MAINT_BASE = 32'he000_ef00;
    localparam logic [ADDR_W-1:0] MAINT_INV_ALL = 32'he000_ef50;
    localparam logic [ADDR_W-1:0] MAINT_INV_LINE = 32'he000_ef58;
    localparam logic [OFF_W-1:0] WORD_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {
        CLH_IDLE,
        CLH_FILL_REQ,
        CLH_FILL_WAIT,
        CLH_BYP_REQ,
        CLH_BYP_WAIT,
        CLH_DONE
    } clh_state_t;
endpackage

// file: clh_tag_store.sv
// Tag and valid store for the cache lines, with line and global invalidation.
`timescale 1ns/10ps
module clh_tag_store
    import clh_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    input wire logic [TAG_W-1:0] rd_tag_i,
    output logic hit_o,
    input wire logic wr_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [TAG_W-1:0] wr_tag_i,
    input wire logic inv_all_i,
    input wire logic inv_line_i,
    input wire logic [IDX_W-1:0] inv_idx_i
);
    logic [TAG_W-1:0] tag_r [SETS];
    logic [SETS-1:0] valid_r;
    logic [SETS-1:0] valid_nxt;

    // A hit needs a valid line with a matching tag.
    assign hit_o = valid_r[rd_idx_i] && (tag_r[rd_idx_i] == rd_tag_i);

    // Invalidation is applied before a new line is marked valid.
    always_comb begin
        valid_nxt = valid_r;
        if (inv_all_i) begin
            valid_nxt = '0;
        end
        if (inv_line_i) begin
            valid_nxt[inv_idx_i] = 1'b0;
        end
        if (wr_i) begin
            valid_nxt[wr_idx_i] = 1'b1;
        end
    end

    // Valid bits reset; tags need no reset because valid guards them.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            valid_r <= '0;
        end else begin
            valid_r <= valid_nxt;
        end
        if (wr_i) begin
            tag_r[wr_idx_i] <= wr_tag_i;
        end
    end
endmodule

// file: clh_data_store.sv
// Data array holding the words of every cache line.
`timescale 1ns/10ps
module clh_data_store
    import clh_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    input wire logic [OFF_W-1:0] rd_word_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic wr_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [OFF_W-1:0] wr_word_i,
    input wire logic [DATA_W-1:0] wr_data_i
);
    logic [DATA_W-1:0] mem_r [SETS*LINE_WORDS];

    // Reads are combinational so that a hit is read in its own cycle and answered in the next.
    assign rd_data_o = mem_r[{rd_idx_i, rd_word_i}];

    // Fill words and write hits land here.
    always_ff @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem_r[{wr_idx_i, wr_word_i}] <= wr_data_i;
        end
    end
endmodule

// file: clh_cache.sv
// Level one cache: lookup, line fill, bypass, preload hints and maintenance.
//
// Function
// RULE_01 - Cacheable access looks up tags; hit answers at once, miss fills whole line. Writes go to the bus; a write miss does not fill.
// RULE_02 - Each entry keeps a tag plus a line of several adjacent words.
// RULE_03 - Memory attributes of every transaction are driven onto the bus.
// RULE_04 - This cache reports itself as level one, nearest the processor.
// RULE_05 - Fetches may run ahead along predicted paths after synchronization.
// RULE_06 - Fetched instructions may be re-executed without being refetched.
// RULE_07 - Instruction side does not snoop memory updates until maintenance.
// RULE_08 - Preload hints start a line fill or do nothing, without visible effect.
// RULE_09 - Preload hints never fault synchronously; bus errors report asynchronously.
// RULE_10 - Maintenance operations are reached through memory-mapped addresses.
// RULE_11 - Non-cacheable accesses bypass the cache without allocating.
`timescale 1ns/10ps
module clh_cache
    import clh_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic [DATA_W-1:0] cpu_wdata_i,
    input wire logic [ATTR_W-1:0] cpu_attr_i,
    input wire logic data_preload_hint_i,
    input wire logic instruction_preload_hint_i,
    output logic cpu_ready_o,
    output logic [DATA_W-1:0] cpu_rdata_o,
    output logic cpu_err_o,
    output logic async_fault_o,
    output logic [1:0] cache_level_o,
    output logic bus_req_o,
    output logic bus_we_o,
    output logic [ADDR_W-1:0] bus_addr_o,
    output logic [DATA_W-1:0] bus_wdata_o,
    output logic [ATTR_W-1:0] bus_attr_o,
    input wire logic bus_ack_i,
    input wire logic [DATA_W-1:0] bus_rdata_i,
    input wire logic bus_err_i
);
    clh_state_t state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [ATTR_W-1:0] attr_r, attr_nxt;
    logic we_r, we_nxt;
    logic hint_r, hint_nxt;
    logic [OFF_W-1:0] word_r, word_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic afault_r, afault_nxt;

    logic [TAG_W-1:0] req_tag;
    logic [IDX_W-1:0] req_idx;
    logic [OFF_W-1:0] req_word;
    logic is_hint, cacheable, hit;
    logic is_maint_all, is_maint_line;
    logic [DATA_W-1:0] store_rdata;
    logic tag_wr, data_wr;
    logic [OFF_W-1:0] data_wr_word;
    logic [DATA_W-1:0] data_wr_data;
    logic [IDX_W-1:0] wr_idx;
    logic [TAG_W-1:0] wr_tag;
    logic hit_write;

    // Address split into tag, set index and word within the line.
    assign req_tag = cpu_addr_i[ADDR_W-1 -: TAG_W]; // [RULE_02]
    assign req_idx = cpu_addr_i[OFF_W+2 +: IDX_W];
    assign req_word = cpu_addr_i[2 +: OFF_W];
    assign is_hint = data_preload_hint_i || instruction_preload_hint_i;
    assign cacheable = |(cpu_attr_i & ATTR_CACHEABLE_BIT); // [RULE_11]
    assign is_maint_all = cpu_we_i && (cpu_addr_i == MAINT_INV_ALL); // [RULE_10]
    assign is_maint_line = cpu_we_i && (cpu_addr_i == MAINT_INV_LINE); // [RULE_10]
    assign wr_idx = addr_r[OFF_W+2 +: IDX_W];
    assign wr_tag = addr_r[ADDR_W-1 -: TAG_W];

    // A write hit in idle updates the stored word to keep the line current.
    assign hit_write = (state_r == CLH_IDLE) && cpu_req_i && !is_hint && cpu_we_i
                       && cacheable && hit && !is_maint_all && !is_maint_line;

    // Tags are checked on the live request; no snoop port exists. [RULE_07]
    clh_tag_store clh_tag_store_inst (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .rd_idx_i(req_idx),
        .rd_tag_i(req_tag),
        .hit_o(hit),
        .wr_i(tag_wr),
        .wr_idx_i(wr_idx),
        .wr_tag_i(wr_tag),
        .inv_all_i((state_r == CLH_IDLE) && cpu_req_i && is_maint_all),
        .inv_line_i((state_r == CLH_IDLE) && cpu_req_i && is_maint_line),
        .inv_idx_i(cpu_wdata_i[OFF_W+2 +: IDX_W])
    );

    clh_data_store clh_data_store_inst (
        .sys_clk_i(sys_clk_i),
        .rd_idx_i(req_idx),
        .rd_word_i(req_word),
        .rd_data_o(store_rdata),
        .wr_i(data_wr),
        .wr_idx_i(hit_write ? req_idx : wr_idx),
        .wr_word_i(data_wr_word),
        .wr_data_i(data_wr_data)
    );

    // Fill writes each returned word; the tag is set with the last word.
    always_comb begin
        data_wr = 1'b0;
        tag_wr = 1'b0;
        data_wr_word = word_r;
        data_wr_data = bus_rdata_i;
        if (hit_write) begin
            data_wr = 1'b1;
            data_wr_word = req_word;
            data_wr_data = cpu_wdata_i;
        end else if (state_r == CLH_FILL_WAIT && bus_ack_i && !bus_err_i) begin
            data_wr = 1'b1; // [RULE_01]
            tag_wr = (word_r == OFF_W'(LINE_WORDS - 1));
        end
    end

    // Next-state logic for the access controller.
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        attr_nxt = attr_r;
        we_nxt = we_r;
        hint_nxt = hint_r;
        word_nxt = word_r;
        rdata_nxt = rdata_r;
        err_nxt = 1'b0;
        afault_nxt = 1'b0;
        unique case (state_r)
            CLH_IDLE: begin
                if (cpu_req_i) begin
                    addr_nxt = cpu_addr_i;
                    wdata_nxt = cpu_wdata_i;
                    attr_nxt = cpu_attr_i;
                    we_nxt = cpu_we_i;
                    hint_nxt = is_hint;
                    if (is_maint_all || is_maint_line) begin
                        state_nxt = CLH_DONE; // [RULE_10]
                    end else if (is_hint && (!cacheable || hit)) begin
                        rdata_nxt = DATA_RESET; // A hint answers with zero data.
                        state_nxt = CLH_DONE; // [RULE_08]
                    end else if (!cacheable) begin
                        state_nxt = CLH_BYP_REQ; // [RULE_11]
                    end else if (hit && !cpu_we_i) begin
                        rdata_nxt = store_rdata; // [RULE_01] [RULE_06]
                        state_nxt = CLH_DONE;
                    end else if (hit) begin
                        state_nxt = CLH_BYP_REQ; // Write-through of a hit.
                    end else if (cpu_we_i) begin
                        state_nxt = CLH_BYP_REQ; // No allocation on a write miss.
                    end else begin
                        word_nxt = WORD_RESET;
                        state_nxt = CLH_FILL_REQ; // [RULE_01]
                    end
                end
            end
            CLH_FILL_REQ: begin
                state_nxt = CLH_FILL_WAIT;
            end
            CLH_FILL_WAIT: begin
                if (bus_ack_i) begin
                    if (word_r == addr_r[2 +: OFF_W] && !hint_r) begin
                        rdata_nxt = bus_rdata_i;
                    end
                    if (bus_err_i) begin
                        err_nxt = !hint_r;
                        afault_nxt = hint_r; // [RULE_09]
                        state_nxt = hint_r ? CLH_IDLE : CLH_DONE;
                    end else if (word_r == OFF_W'(LINE_WORDS - 1)) begin
                        state_nxt = hint_r ? CLH_IDLE : CLH_DONE;
                    end else begin
                        word_nxt = word_r + 1'b1; // [RULE_05]
                        state_nxt = CLH_FILL_REQ;
                    end
                end
            end
            CLH_BYP_REQ: begin
                state_nxt = CLH_BYP_WAIT;
            end
            CLH_BYP_WAIT: begin
                if (bus_ack_i) begin
                    rdata_nxt = bus_rdata_i;
                    err_nxt = bus_err_i;
                    state_nxt = CLH_DONE;
                end
            end
            CLH_DONE: begin
                state_nxt = CLH_IDLE;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= CLH_IDLE;
            addr_r <= '0;
            wdata_r <= DATA_RESET;
            attr_r <= ATTR_RESET;
            we_r <= 1'b0;
            hint_r <= 1'b0;
            word_r <= WORD_RESET;
            rdata_r <= DATA_RESET;
            err_r <= 1'b0;
            afault_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            attr_r <= attr_nxt;
            we_r <= we_nxt;
            hint_r <= hint_nxt;
            word_r <= word_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            afault_r <= afault_nxt;
        end
    end

    // Ready pulses once per answer; a hinted miss fills on its own and gives no answer.
    assign cpu_ready_o = (state_r == CLH_DONE); // [RULE_08]
    assign cpu_rdata_o = rdata_r;
    assign cpu_err_o = err_r && !hint_r; // [RULE_09]
    assign async_fault_o = afault_r; // [RULE_09]
    assign cache_level_o = CACHE_LEVEL; // [RULE_04]

    // Bus side: fills fetch word by word; attributes travel with each request.
    assign bus_req_o = (state_r == CLH_FILL_REQ) || (state_r == CLH_BYP_REQ);
    assign bus_we_o = (state_r == CLH_BYP_REQ) && we_r;
    assign bus_addr_o = (state_r == CLH_FILL_REQ)
                        ? {addr_r[ADDR_W-1:OFF_W+2], word_r, 2'h0} : addr_r;
    assign bus_wdata_o = wdata_r;
    assign bus_attr_o = attr_r; // [RULE_03]

    // Instructions held here are served again on later fetches. [RULE_05] [RULE_06]
endmodule

// file: clh_cache_checker.sv
// Checker of port timing for the cache block.
`timescale 1ns/10ps
module clh_cache_checker
    import clh_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic [ATTR_W-1:0] cpu_attr_i,
    input wire logic data_preload_hint_i,
    input wire logic instruction_preload_hint_i,
    input wire logic cpu_ready_o,
    input wire logic cpu_err_o,
    input wire logic async_fault_o,
    input wire logic [1:0] cache_level_o,
    input wire logic bus_req_o,
    input wire logic bus_we_o,
    input wire logic [ADDR_W-1:0] bus_addr_o,
    input wire logic [ATTR_W-1:0] bus_attr_o,
    input wire logic bus_ack_i,
    input wire logic bus_err_i
);
    logic hint;
    logic [1:0] word_r;
    logic [1:0] word_nxt;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Remembers the word of the latest beat so that fill order can be checked.
    assign hint = data_preload_hint_i | instruction_preload_hint_i;
    always_comb word_nxt = bus_req_o ? bus_addr_o[3:2] : word_r;
    always_ff @(posedge sys_clk_i) word_r <= word_nxt;
    AST_LEVEL: assert property (cache_level_o == 2'h1)
        else $error("Cache level is not one.");
    AST_READY_PULSE: assert property (cpu_ready_o |=> !cpu_ready_o)
        else $error("Ready lasted more than one cycle.");
    AST_ERR_READY: assert property (cpu_err_o |-> cpu_ready_o && !hint)
        else $error("Error outside a plain answer.");
    AST_ATTR: assert property (bus_req_o |-> bus_attr_o == cpu_attr_i)
        else $error("Bus attributes differ from the request.");
    AST_FILL_NEXT: assert property (bus_req_o && !bus_we_o && bus_attr_o[0]
        && bus_addr_o[3:2] != 2'h0 |-> bus_addr_o[3:2] == word_r + 2'h1)
        else $error("Fill beats out of order.");
    AST_FILL_DONE: assert property (bus_ack_i && !bus_err_i && !hint && !bus_we_o
        && bus_attr_o[0] && word_r == 2'h3 |-> ##[1:2] cpu_ready_o)
        else $error("Fill finished without an answer.");
    AST_NC_BYPASS: assert property (bus_req_o && !bus_attr_o[0]
        |-> bus_addr_o == cpu_addr_i && !hint)
        else $error("Uncached beat has a wrong address.");
    AST_NC_READY: assert property (bus_ack_i && !bus_attr_o[0]
        |-> ##[1:2] cpu_ready_o)
        else $error("Uncached access not answered.");
    AST_HINT_FAULT: assert property (bus_ack_i && bus_err_i && hint
        |-> ##[1:3] async_fault_o)
        else $error("Hint bus error gave no fault.");
endmodule

// file: clh_mem_model.sv
// Behavioural next-level memory answering single-word bus beats.
`timescale 1ns/10ps
module clh_mem_model
    import clh_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic bus_req_i,
    input wire logic bus_we_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_wdata_i,
    input wire logic slow_i,
    input wire logic err_i,
    output logic bus_ack_o,
    output logic [DATA_W-1:0] bus_rdata_o,
    output logic bus_err_o
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] addr_r = '0;
    int wait_r = -1;
    // A beat waits 0 or 3 cycles, then gets one ack; idle read data shows a wrong word.
    always @(posedge sys_clk_i) begin
        bus_ack_o <= 1'b0;
        bus_err_o <= 1'b0;
        bus_rdata_o <= ~addr_r;
        if (bus_req_i) begin
            addr_r <= bus_addr_i;
            wait_r <= slow_i ? 3 : 0;
            if (bus_we_i && !err_i) mem[bus_addr_i] = bus_wdata_i;
        end else if (wait_r > 0) begin
            wait_r <= wait_r - 1;
        end else if (wait_r == 0) begin
            wait_r <= -1;
            bus_ack_o <= 1'b1;
            bus_err_o <= err_i;
            bus_rdata_o <= mem.exists(addr_r) ? mem[addr_r] : addr_r ^ 32'h5a5a_5a5a;
        end
    end
endmodule

// file: clh_cache_tb.sv
// Self-checking bench for the cache block with a behavioural memory.
`timescale 1ns/10ps
module clh_cache_tb
    import clh_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cpu_req_i = 1'b0;
    logic cpu_we_i = 1'b0;
    logic [ADDR_W-1:0] cpu_addr_i = '0;
    logic [DATA_W-1:0] cpu_wdata_i = '0;
    logic [ATTR_W-1:0] cpu_attr_i = '0;
    logic [1:0] hint = 2'h0;
    logic slow = 1'b0;
    logic mem_err = 1'b0;
    logic cpu_ready_o, cpu_err_o, async_fault_o, bus_req_o, bus_we_o, bus_ack_i, bus_err_i;
    logic err_seen;
    logic [1:0] cache_level_o;
    logic [ADDR_W-1:0] bus_addr_o;
    logic [DATA_W-1:0] cpu_rdata_o, bus_wdata_o, bus_rdata_i, rd_seen;
    logic [ATTR_W-1:0] bus_attr_o;
    logic [ATTR_W-1:0] attr_seen = '0;
    int err_total = 0;
    int comparisons = 0;
    int beats, readies, faults;
    int cycles = 0;
    clh_cache clh_cache_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_req_i(cpu_req_i),
        .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_attr_i(cpu_attr_i), .data_preload_hint_i(hint[1]),
        .instruction_preload_hint_i(hint[0]), .cpu_ready_o(cpu_ready_o),
        .cpu_rdata_o(cpu_rdata_o), .cpu_err_o(cpu_err_o), .async_fault_o(async_fault_o),
        .cache_level_o(cache_level_o), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o),
        .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_attr_o(bus_attr_o),
        .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i), .bus_err_i(bus_err_i));
    clh_mem_model clh_mem_model_inst (.sys_clk_i(sys_clk_i), .bus_req_i(bus_req_o),
        .bus_we_i(bus_we_o), .bus_addr_i(bus_addr_o), .bus_wdata_i(bus_wdata_o),
        .slow_i(slow), .err_i(mem_err), .bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i),
        .bus_err_o(bus_err_i));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    // Counts beats, answers and faults, and cuts a hung run short.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (bus_req_o) begin
            beats++;
            attr_seen = bus_attr_o;
        end
        if (async_fault_o) faults++;
        if (cpu_ready_o) begin
            readies++;
            rd_seen = cpu_rdata_o;
            err_seen = cpu_err_o;
        end
        if (cycles == 5000) begin
            err_total++;
            summarize();
        end
    end
    // Compares one value and reports a difference.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One access: d is write data or expected read data; a hint that misses gets no answer.
    task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] at, input logic [1:0] h, input int nb, input logic ee);
        int n;
        logic rdy;
        rdy = (h == 2'h0) || (nb == 0);
        beats = 0;
        readies = 0;
        cpu_we_i = we;
        cpu_addr_i = a;
        cpu_wdata_i = d;
        cpu_attr_i = at;
        hint = h;
        cpu_req_i = 1'b1;
        @(posedge sys_clk_i);
        #1 cpu_req_i = 1'b0;
        n = 0;
        while ((readies == 0 || !rdy) && n < 60) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        chk(32'(readies), 32'(rdy));
        chk(32'(beats), 32'(nb));
        if (rdy && !we && !ee) chk(rd_seen, h != 2'h0 ? 32'h0 : d);
        if (rdy) chk(32'(err_seen), 32'(ee));
    endtask
    // Miss fills a whole line, later words hit without bus traffic.
    task automatic s_fill();
        slow = 1'b1;
        access(1'b0, 32'h1000, 32'h1000 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 4, 1'b0);
        chk(32'(attr_seen), 32'h1);
        chk(32'(cache_level_o), 32'h1);
        access(1'b0, 32'h1004, 32'h1004 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 0, 1'b0);
        access(1'b0, 32'h100c, 32'h100c ^ 32'h5a5a_5a5a, 4'hf, 2'h0, 0, 1'b0);
        slow = 1'b0;
    endtask
    // Uncached reads and writes go to the bus every time.
    task automatic s_bypass();
        access(1'b0, 32'h4000_0000, 32'h1a5a_5a5a, 4'h0, 2'h0, 1, 1'b0);
        access(1'b0, 32'h4000_0000, 32'h1a5a_5a5a, 4'h0, 2'h0, 1, 1'b0);
        access(1'b1, 32'h4000_0004, 32'h0bad_cafe, 4'he, 2'h0, 1, 1'b0);
        chk(32'(attr_seen), 32'he);
        access(1'b0, 32'h4000_0004, 32'h0bad_cafe, 4'h0, 2'h0, 1, 1'b0);
    endtask
    // Write hit updates the line; write miss does not allocate.
    task automatic s_write();
        access(1'b1, 32'h1008, 32'h1234_5678, 4'h1, 2'h0, 1, 1'b0);
        access(1'b1, 32'h1008, 32'h0bad_0008, 4'h0, 2'h0, 1, 1'b0);
        access(1'b0, 32'h1008, 32'h1234_5678, 4'h1, 2'h0, 0, 1'b0);
        access(1'b1, 32'h2010, 32'h8765_4321, 4'h1, 2'h0, 1, 1'b0);
        access(1'b0, 32'h2010, 32'h8765_4321, 4'h1, 2'h0, 4, 1'b0);
    endtask
    // Hints fill silently on a miss and answer with zero otherwise.
    task automatic s_hint();
        access(1'b0, 32'h3000, 32'h0, 4'h1, 2'h2, 4, 1'b0);
        access(1'b0, 32'h3004, 32'h3004 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 0, 1'b0);
        access(1'b0, 32'h1000, 32'h1000 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 4, 1'b0);
        access(1'b0, 32'h1000, 32'h0, 4'h1, 2'h1, 0, 1'b0);
        access(1'b0, 32'h4000_0000, 32'h0, 4'h0, 2'h1, 0, 1'b0);
    endtask
    // Global and single-set invalidation through the mapped addresses.
    task automatic s_maint();
        access(1'b1, MAINT_INV_ALL, 32'h0, 4'h0, 2'h0, 0, 1'b0);
        access(1'b0, 32'h1000, 32'h1000 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 4, 1'b0);
        access(1'b0, 32'h2010, 32'h8765_4321, 4'h1, 2'h0, 4, 1'b0);
        access(1'b1, MAINT_INV_LINE, 32'h0, 4'h0, 2'h0, 0, 1'b0);
        access(1'b0, 32'h1004, 32'h1004 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 4, 1'b0);
        access(1'b0, 32'h2014, 32'h2014 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 0, 1'b0);
    endtask
    // Bus errors abort fills; a hint reports them only as a late fault.
    task automatic s_err();
        mem_err = 1'b1;
        access(1'b0, 32'h5020, 32'h0, 4'h1, 2'h0, 1, 1'b1);
        faults = 0;
        access(1'b0, 32'h5020, 32'h0, 4'h1, 2'h1, 1, 1'b0);
        chk(32'(faults), 32'h1);
        mem_err = 1'b0;
        access(1'b0, 32'h5024, 32'h5024 ^ 32'h5a5a_5a5a, 4'h1, 2'h0, 4, 1'b0);
    endtask
    // Reset for two cycles, then run every scenario.
    initial begin
        repeat (2) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        s_fill();
        s_bypass();
        s_write();
        s_hint();
        s_maint();
        s_err();
        summarize();
    end
endmodule
bind clh_cache clh_cache_checker clh_cache_checker_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .cpu_addr_i(cpu_addr_i), .cpu_attr_i(cpu_attr_i), .data_preload_hint_i(data_preload_hint_i),
    .instruction_preload_hint_i(instruction_preload_hint_i), .cpu_ready_o(cpu_ready_o),
    .cpu_err_o(cpu_err_o), .async_fault_o(async_fault_o), .cache_level_o(cache_level_o),
    .bus_req_o(bus_req_o), .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o),
    .bus_attr_o(bus_attr_o), .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i));
